// ===== design/drc_pkg.sv
// shared types, indices and reset values of the debug run-control block
package drc_pkg;

    // ---------------------------------------------------------------
    // run states and instruction classes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {ST_RUN, ST_BREAK, ST_STEP, ST_SRC_STEP} drc_state_t;

    typedef enum logic [3:0] {
        CLS_PLAIN,
        CLS_RMW,
        CLS_COMPARE_EXCHANGE_INSTR,
        CLS_BIT_SET_INSTR,
        CLS_BIT_CLEAR_INSTR,
        CLS_BIT_INVERT_INSTR,
        CLS_BIT_TEST_INSTR,
        CLS_FRAME_BUILD_INSTR,
        CLS_FRAME_RELEASE_INSTR,
        CLS_STACK_PUSH_INSTR,
        CLS_STACK_POP_INSTR,
        CLS_TABLE_JUMP_INSTR,
        CLS_TABLE_CALL_INSTR,
        CLS_SYSTEM_CALL_INSTR
    } drc_class_t;

    // ---------------------------------------------------------------
    // widths, indices, reset values
    // ---------------------------------------------------------------
    localparam int DRC_AW = 32;
    localparam int DRC_DW = 32;
    localparam int DRC_IRQ_N = 3;
    localparam int IRQ_MASKABLE = 0;
    localparam int IRQ_FAST_LEVEL = 1;
    localparam int IRQ_FLOAT_UNIT = 2;
    localparam int DRC_SYNC_W = 7;
    localparam int SY_BRK = 0;
    localparam int SY_RUN = 1;
    localparam int SY_STEP = 2;
    localparam int SY_SRC = 3;
    localparam int SY_DRST = 4;
    localparam int SY_CONN = 5;
    localparam int SY_PRST_N = 6;
    localparam drc_state_t DRC_RST_STATE = ST_RUN;
    localparam logic [DRC_SYNC_W-1:0] DRC_SYNC_RST = 7'h40;

    // ---------------------------------------------------------------
    // class decode, used by break and trace matchers
    // ---------------------------------------------------------------
    function automatic logic drc_never_match(input drc_class_t c);
        return c inside {CLS_FRAME_BUILD_INSTR, CLS_FRAME_RELEASE_INSTR, CLS_STACK_PUSH_INSTR,
                         CLS_STACK_POP_INSTR, CLS_TABLE_JUMP_INSTR, CLS_TABLE_CALL_INSTR,
                         CLS_SYSTEM_CALL_INSTR};
    endfunction

    function automatic logic drc_bit_class(input drc_class_t c);
        return c inside {CLS_COMPARE_EXCHANGE_INSTR, CLS_BIT_SET_INSTR, CLS_BIT_CLEAR_INSTR,
                         CLS_BIT_INVERT_INSTR, CLS_BIT_TEST_INSTR};
    endfunction

endpackage

// ===== design/drc_sync.sv
// two-flop synchroniser for the emulator and target pins
`timescale 1ns/1ns
module drc_sync
    import drc_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire logic [DRC_SYNC_W-1:0] pin_in,
    output logic      [DRC_SYNC_W-1:0] pin_sync
);

    typedef struct packed {
        logic [DRC_SYNC_W-1:0] s1;
        logic [DRC_SYNC_W-1:0] s2;
    } drc_sync_st_t;

    drc_sync_st_t st_q;
    drc_sync_st_t st_d;

    // ---------------------------------------------------------------
    // first stage feeds only the second stage
    // ---------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
    end

    // reset value keeps the active-low pin reset idle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= {DRC_SYNC_RST, DRC_SYNC_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_sync = st_q.s2;

endmodule

// ===== design/drc_match.sv
// access matcher shared by hardware break and point trace
`timescale 1ns/1ns
module drc_match
    import drc_pkg::*;
(
    input  wire logic              acc_valid,
    input  wire logic              acc_write,
    input  wire logic [DRC_AW-1:0] acc_addr,
    input  wire logic [DRC_DW-1:0] acc_data,
    input  wire drc_class_t        acc_class,
    input  wire logic              cond_en,
    input  wire logic [DRC_AW-1:0] cond_addr,
    input  wire logic [DRC_DW-1:0] cond_data,
    input  wire logic              cond_data_en,
    input  wire logic              cond_rd_en,
    input  wire logic              cond_wr_en,
    input  wire logic              ign_data,
    output logic                   hit,
    output logic                   rmw_hit
);

    logic addr_ok;
    logic dir_ok;
    logic data_ok;
    logic plain_ok;
    logic bit_rd_ok;

    // ---------------------------------------------------------------
    // address, direction and optional data qualifier
    // ---------------------------------------------------------------
    always_comb begin
        addr_ok   = acc_valid & cond_en & (acc_addr == cond_addr);
        dir_ok    = acc_write ? cond_wr_en : cond_rd_en;
        data_ok   = ~cond_data_en | ign_data | (acc_data == cond_data);
        plain_ok  = ~drc_never_match(acc_class) & ~drc_bit_class(acc_class);
        bit_rd_ok = drc_bit_class(acc_class) & ~acc_write & ~cond_data_en;
        hit       = addr_ok & dir_ok & ((plain_ok & data_ok) | bit_rd_ok);
        // data-qualified hit of a rmw access is taken after it retires
        rmw_hit   = hit & (acc_class == CLS_RMW) & cond_data_en & ~ign_data;
    end

endmodule

// ===== design/drc_top.sv
// debug run control: break, step, reset and interrupt masking, trace flags
`timescale 1ns/1ns
module drc_top
    import drc_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 dbg_break_req,
    input  wire logic                 dbg_run_req,
    input  wire logic                 dbg_step_req,
    input  wire logic                 dbg_src_step_req,
    input  wire logic                 dbg_reset_req,
    input  wire logic                 dbg_connected,
    input  wire logic                 target_reset_n,
    input  wire logic                 src_mask_sel,
    input  wire logic                 dbg_mem_access,
    input  wire logic                 dbg_event_set,
    input  wire logic                 acc_valid,
    input  wire logic                 acc_write,
    input  wire logic [DRC_AW-1:0]    acc_addr,
    input  wire logic [DRC_DW-1:0]    acc_data,
    input  wire drc_class_t           acc_class,
    input  wire logic                 instr_retire,
    input  wire logic                 retire_halt,
    input  wire logic                 retire_dstby,
    input  wire logic                 sw_reset_req,
    input  wire logic [DRC_IRQ_N-1:0] irq_req,
    input  wire logic [DRC_IRQ_N-1:0] irq_ack,
    input  wire logic                 brk_en,
    input  wire logic [DRC_AW-1:0]    brk_addr,
    input  wire logic [DRC_DW-1:0]    brk_data,
    input  wire logic                 brk_data_en,
    input  wire logic                 brk_rd_en,
    input  wire logic                 brk_wr_en,
    input  wire logic                 trc_en,
    input  wire logic                 trc_point_mode,
    input  wire logic [DRC_AW-1:0]    trc_addr,
    input  wire logic [DRC_DW-1:0]    trc_data,
    input  wire logic                 trc_data_en,
    input  wire logic                 trc_rd_en,
    input  wire logic                 trc_wr_en,
    input  wire logic                 trc_valid,
    input  wire logic                 trc_ready,
    input  wire logic                 trc_loss_clr,
    output drc_state_t                run_state,
    output logic                      cpu_reset,
    output logic                      brk_before,
    output logic                      brk_after,
    output logic                      brk_at_reset_vec,
    output logic                      halt_mode,
    output logic                      deep_standby_mode,
    output logic                      dstby_wake,
    output logic                      iso_power_off,
    output logic [DRC_IRQ_N-1:0]      irq_fwd,
    output logic                      trc_record,
    output logic                      trc_loss
);

    typedef struct packed {
        drc_state_t            state;
        logic [DRC_SYNC_W-1:0] pin_prev;
        logic                  cpu_rst;
        logic                  brk_bef;
        logic                  brk_aft;
        logic                  brk_rst_vec;
        logic                  rmw_pend;
        logic                  halt;
        logic                  dstby;
        logic                  wake;
        logic                  iso_off;
        logic [DRC_IRQ_N-1:0]  irq_pend;
        logic [DRC_IRQ_N-1:0]  irq_out;
        logic                  trc_rec;
        logic                  trc_lost;
    } drc_st_t;

    drc_st_t               st_q;
    drc_st_t               st_d;
    logic [DRC_SYNC_W-1:0] pin_s;
    logic [DRC_SYNC_W-1:0] pin_rise;
    logic                  acc_hit;
    logic                  acc_rmw;
    logic                  trc_hit;
    logic                  masked_q;
    logic                  masked_d;
    logic                  user_rst_ev;
    logic                  dbg_rst_ev;
    logic                  brk_rise;
    logic                  rmw_done;
    logic                  brk_ev;

    // ---------------------------------------------------------------
    // pin synchronisation and matchers
    // ---------------------------------------------------------------
    drc_sync u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .pin_in   ({target_reset_n, dbg_connected, dbg_reset_req, dbg_src_step_req,
                    dbg_step_req, dbg_run_req, dbg_break_req}),
        .pin_sync (pin_s)
    );

    drc_match u_brk (
        .acc_valid    (acc_valid),
        .acc_write    (acc_write),
        .acc_addr     (acc_addr),
        .acc_data     (acc_data),
        .acc_class    (acc_class),
        .cond_en      (brk_en),
        .cond_addr    (brk_addr),
        .cond_data    (brk_data),
        .cond_data_en (brk_data_en),
        .cond_rd_en   (brk_rd_en),
        .cond_wr_en   (brk_wr_en),
        .ign_data     (1'b0),
        .hit          (acc_hit),
        .rmw_hit      (acc_rmw)
    );

    // point trace drops the data term, other qualifiers still apply
    drc_match u_trc (
        .acc_valid    (acc_valid),
        .acc_write    (acc_write),
        .acc_addr     (acc_addr),
        .acc_data     (acc_data),
        .acc_class    (acc_class),
        .cond_en      (trc_en),
        .cond_addr    (trc_addr),
        .cond_data    (trc_data),
        .cond_data_en (trc_data_en),
        .cond_rd_en   (trc_rd_en),
        .cond_wr_en   (trc_wr_en),
        .ign_data     (trc_point_mode),
        .hit          (trc_hit),
        .rmw_hit      ()
    );

    // ---------------------------------------------------------------
    // events; pin reset is active low, so its rise is a fall
    // ---------------------------------------------------------------
    always_comb begin
        pin_rise = pin_s & ~st_q.pin_prev;
        pin_rise[SY_PRST_N] = ~pin_s[SY_PRST_N] & st_q.pin_prev[SY_PRST_N];
        // source-level stepping masks only when the debugger asks
        masked_q = (st_q.state == ST_BREAK) | (st_q.state == ST_STEP) |
                   ((st_q.state == ST_SRC_STEP) & src_mask_sel);
        dbg_rst_ev  = pin_rise[SY_DRST];
        user_rst_ev = sw_reset_req | pin_rise[SY_PRST_N];
        brk_rise    = pin_rise[SY_BRK];
        rmw_done    = st_q.rmw_pend & instr_retire;
        brk_ev      = brk_rise | (acc_hit & ~acc_rmw) | rmw_done;
    end

    // ---------------------------------------------------------------
    // run-control state machine
    // ---------------------------------------------------------------
    always_comb begin
        st_d             = st_q;
        st_d.pin_prev    = pin_s;
        st_d.cpu_rst     = 1'b0;
        st_d.brk_bef     = 1'b0;
        st_d.brk_aft     = 1'b0;
        st_d.brk_rst_vec = 1'b0;
        st_d.wake        = 1'b0;
        if (dbg_rst_ev) begin
            // debugger reset ignores every mask and lands in break
            st_d.cpu_rst  = 1'b1;
            st_d.state    = ST_BREAK;
            st_d.halt     = 1'b0;
            st_d.dstby    = 1'b0;
            st_d.rmw_pend = 1'b0;
        end else if (user_rst_ev && !masked_q) begin
            st_d.cpu_rst  = 1'b1;
            st_d.halt     = 1'b0;
            st_d.dstby    = 1'b0;
            st_d.rmw_pend = 1'b0;
        end else begin
            // a masked user reset falls through here and is lost
            unique case (st_q.state)
                ST_RUN, ST_SRC_STEP: begin
                    if (brk_ev) begin
                        st_d.state    = ST_BREAK;
                        st_d.brk_bef  = ~rmw_done;
                        st_d.brk_aft  = rmw_done;
                        st_d.rmw_pend = 1'b0;
                        st_d.halt     = 1'b0;
                        if (st_q.dstby) begin
                            st_d.dstby = 1'b0;
                            st_d.wake  = 1'b1;
                        end
                    end else begin
                        if (acc_rmw) begin
                            st_d.rmw_pend = 1'b1;
                        end
                        if (st_q.dstby && (dbg_mem_access || dbg_event_set)) begin
                            st_d.dstby = 1'b0;
                            st_d.wake  = 1'b1;
                        end
                        if (instr_retire && retire_halt) begin
                            st_d.halt = 1'b1;
                        end
                        if (instr_retire && retire_dstby) begin
                            st_d.dstby = 1'b1;
                        end
                    end
                end
                ST_BREAK: begin
                    if (pin_rise[SY_RUN]) begin
                        st_d.state = ST_RUN;
                    end else if (pin_rise[SY_STEP]) begin
                        st_d.state = ST_STEP;
                    end else if (pin_rise[SY_SRC]) begin
                        st_d.state = ST_SRC_STEP;
                    end
                end
                ST_STEP: begin
                    // one instruction, then back to break; halt and standby never entered
                    if (brk_rise) begin
                        st_d.state   = ST_BREAK;
                        st_d.brk_bef = 1'b1;
                    end else if (instr_retire) begin
                        st_d.state       = ST_BREAK;
                        st_d.brk_aft     = 1'b1;
                        st_d.brk_rst_vec = retire_dstby;
                    end
                end
            endcase
        end
        masked_d = (st_d.state == ST_BREAK) | (st_d.state == ST_STEP) |
                   ((st_d.state == ST_SRC_STEP) & src_mask_sel);
        // new request wins over an acknowledge in the same cycle
        st_d.irq_pend = (st_q.irq_pend & ~(irq_ack & st_q.irq_out)) | irq_req;
        st_d.irq_out  = st_d.irq_pend & {DRC_IRQ_N{~masked_d}};
        st_d.iso_off  = st_d.dstby & ~pin_s[SY_CONN];
        st_d.trc_rec  = trc_hit;
        // lost records are not kept, only counted as a flag; set beats clear
        st_d.trc_lost = (st_q.trc_lost & ~trc_loss_clr) | (trc_valid & ~trc_ready);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q          <= '0;
            st_q.state    <= DRC_RST_STATE;
            st_q.pin_prev <= DRC_SYNC_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs straight from the state register
    // ---------------------------------------------------------------
    assign run_state         = st_q.state;
    assign cpu_reset         = st_q.cpu_rst;
    assign brk_before        = st_q.brk_bef;
    assign brk_after         = st_q.brk_aft;
    assign brk_at_reset_vec  = st_q.brk_rst_vec;
    assign halt_mode         = st_q.halt;
    assign deep_standby_mode = st_q.dstby;
    assign dstby_wake        = st_q.wake;
    assign iso_power_off     = st_q.iso_off;
    assign irq_fwd           = st_q.irq_out;
    assign trc_record        = st_q.trc_rec;
    assign trc_loss          = st_q.trc_lost;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_rmw_after_break: assert property (
        (st_q.state == ST_RUN) && rmw_done && !dbg_rst_ev && !(user_rst_ev && !masked_q)
        |=> brk_after && !brk_before && (run_state == ST_BREAK))
        else $error("rmw break not taken after the instruction");

    chk_excluded_class: assert property (
        drc_never_match(acc_class) |-> !acc_hit && !trc_hit)
        else $error("excluded instruction matched a break");

    chk_bit_data_qual: assert property (
        drc_bit_class(acc_class) && brk_data_en |-> !acc_hit)
        else $error("bit instruction matched a data condition");

    chk_trace_loss: assert property (
        trc_valid && !trc_ready |=> trc_loss ##1 (trc_loss || $past(trc_loss_clr)))
        else $error("trace loss flag not held");

    chk_point_trace: assert property (
        trc_point_mode && trc_en && acc_valid && !acc_write && trc_rd_en &&
        (acc_addr == trc_addr) && (acc_class == CLS_PLAIN) |=> trc_record)
        else $error("point trace applied a data condition");

    chk_dstby_wake: assert property (
        deep_standby_mode && (run_state == ST_RUN) && dbg_mem_access |=> !deep_standby_mode ##0 dstby_wake)
        else $error("deep standby not left on debugger access");

    chk_iso_power: assert property (
        pin_s[SY_CONN] && $past(pin_s[SY_CONN]) |-> !iso_power_off)
        else $error("isolated domain powered down while debugging");

    chk_user_rst_mask: assert property (
        masked_q && user_rst_ev && !dbg_rst_ev |=> !cpu_reset ##1 !cpu_reset || $past(dbg_rst_ev))
        else $error("masked user reset reached the cpu");

    chk_dbg_reset: assert property (
        dbg_rst_ev |=> cpu_reset && (run_state == ST_BREAK))
        else $error("debugger reset did not reset and break");

    chk_irq_masked: assert property (
        (run_state == ST_BREAK) || (run_state == ST_STEP) |-> irq_fwd == '0)
        else $error("interrupt passed while masked");

    chk_irq_pending: assert property (
        irq_req[IRQ_MASKABLE] && masked_q ##1 (masked_q && !irq_ack[IRQ_MASKABLE]) [*2]
        |-> st_q.irq_pend[IRQ_MASKABLE])
        else $error("masked interrupt not held pending");

    chk_halt_release: assert property (
        halt_mode && brk_rise && !dbg_rst_ev && (run_state == ST_RUN) |=> !halt_mode)
        else $error("break did not release halt");

    chk_step_halt: assert property (
        (run_state == ST_STEP) && instr_retire && !brk_rise && !dbg_rst_ev && !user_rst_ev
        |=> (run_state == ST_BREAK) && ($stable(halt_mode)) && brk_after)
        else $error("stepped halt entered halt mode");

    cov_access_break: cover property (
        (run_state == ST_RUN) ##1 brk_before ##[1:20] (run_state == ST_RUN));
    cov_step_dstby: cover property ((run_state == ST_STEP) ##[1:20] brk_at_reset_vec);
    cov_irq_release: cover property (masked_q && irq_req != '0 ##[1:50] irq_fwd != '0);
    cov_dbg_reset: cover property (dbg_rst_ev ##1 cpu_reset ##[1:20] (run_state == ST_STEP));

endmodule

// ===== tb/drc_emu_model.sv
// behavioural emulator pod driving the debug request pins
`timescale 1ns/1ns
module drc_emu_model (
    input  wire logic sys_clk,
    output logic [4:0] req,
    output logic       conn
);
    // ---------------------------------------------
    // request pins: 0 break 1 run 2 step 3 src 4 reset
    // ---------------------------------------------
    initial begin
        req = 5'h0;
        conn = 1'b1;
    end
    // held four edges so the two-flop sync sees it; dropped so the next one is a new edge
    task automatic pulse(input int i);
        @(posedge sys_clk);
        #2 req[i] = 1'b1;
        repeat (4) @(posedge sys_clk);
        #2 req[i] = 1'b0;
    endtask
endmodule

// ===== tb/drc_top_tb_top.sv
// self-checking bench for the debug run-control block
`timescale 1ns/1ns
module drc_top_tb_top import drc_pkg::*;;
    // ---------------------------------------------
    // signals, partner and design
    // ---------------------------------------------
    logic sys_clk = 1'b0;
    logic reset_n, target_reset_n, src_mask_sel, dbg_mem_access, dbg_event_set, acc_valid, acc_write;
    logic instr_retire, retire_halt, retire_dstby, sw_reset_req, brk_en, brk_data_en, brk_rd_en, brk_wr_en;
    logic trc_en, trc_point_mode, trc_data_en, trc_rd_en, trc_wr_en, trc_valid, trc_ready, trc_loss_clr;
    logic [DRC_AW-1:0] acc_addr, brk_addr, trc_addr;
    logic [DRC_DW-1:0] acc_data, brk_data, trc_data;
    logic [DRC_IRQ_N-1:0] irq_req, irq_ack, irq_fwd;
    drc_class_t acc_class;
    drc_state_t run_state;
    logic cpu_reset, brk_before, brk_after, brk_at_reset_vec, halt_mode, deep_standby_mode;
    logic dstby_wake, iso_power_off, trc_record, trc_loss, dbg_connected;
    logic [4:0] req;
    int bad_count = 0, total_checks = 0, cycles = 0, n_rst, n_bb, n_ba, n_rv, n_tr;
    wire logic dbg_break_req = req[0];
    wire logic dbg_run_req = req[1];
    wire logic dbg_step_req = req[2];
    wire logic dbg_src_step_req = req[3];
    wire logic dbg_reset_req = req[4];
    drc_emu_model u_emu (.sys_clk(sys_clk), .req(req), .conn(dbg_connected));
    drc_top uut (.*);
    always #10 sys_clk = ~sys_clk;
    // pulse counters sampled mid-cycle, where outputs are settled
    always @(negedge sys_clk) begin
        n_rst += cpu_reset;
        n_bb += brk_before;
        n_ba += brk_after;
        n_rv += brk_at_reset_vec;
        n_tr += trc_record;
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
        {n_rst, n_bb, n_ba, n_rv, n_tr} = '0;
    endtask
    task automatic ret(input logic h, input logic d);
        @(posedge sys_clk);
        #2 {instr_retire, retire_halt, retire_dstby} = {1'b1, h, d};
        cyc(1);
        {instr_retire, retire_halt, retire_dstby} = 3'h0;
        cyc(1);
    endtask
    task automatic acc(input drc_class_t c, input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        #2 {acc_valid, acc_write, acc_addr, acc_data} = {1'b1, w, a, d};
        acc_class = c;
        cyc(1);
        acc_valid = 1'b0;
    endtask
    // halt while running, then a forced break wakes it
    task automatic t_halt();
        ret(1'b1, 1'b0);
        chk(halt_mode, 1'b1);
        u_emu.pulse(0);
        chk(halt_mode, 1'b0);
        chk(n_bb, 1);
        @(posedge sys_clk);
        #2 irq_req = 3'h7;
        cyc(1);
        irq_req = 3'h0;
        cyc(3);
        chk(irq_fwd, 3'h0);
        u_emu.pulse(1);
        chk(irq_fwd, 3'h7);
        irq_ack = 3'h5;
        cyc(1);
        irq_ack = 3'h0;
        cyc(1);
        chk(irq_fwd, 3'h2);
        fin("halt_irq");
    endtask
    // pin reset while running, dropped soft reset in break, debugger reset
    task automatic t_resets();
        target_reset_n = 1'b0;
        cyc(4);
        target_reset_n = 1'b1;
        chk(n_rst, 1);
        u_emu.pulse(0);
        sw_reset_req = 1'b1;
        cyc(1);
        sw_reset_req = 1'b0;
        cyc(4);
        chk(n_rst, 1);
        u_emu.pulse(4);
        chk(n_rst, 2);
        chk(run_state, ST_BREAK);
        u_emu.pulse(1);
        cyc(4);
        chk(n_rst, 2);
        fin("resets");
    endtask
    // stepping halt and deep-standby entry instructions
    task automatic t_step();
        u_emu.pulse(0);
        u_emu.pulse(2);
        chk(run_state, ST_STEP);
        ret(1'b1, 1'b0);
        chk(halt_mode, 1'b0);
        chk(n_ba, 1);
        u_emu.pulse(2);
        ret(1'b0, 1'b1);
        chk(deep_standby_mode, 1'b0);
        chk(n_rv, 1);
        fin("step");
    endtask
    // source-level stepping masks resets and interrupts only when selected
    task automatic t_src();
        u_emu.pulse(3);
        chk(irq_fwd, 3'h2);
        sw_reset_req = 1'b1;
        cyc(1);
        {sw_reset_req, src_mask_sel} = 2'h1;
        cyc(1);
        chk(n_rst, 1);
        chk(irq_fwd, 3'h0);
        sw_reset_req = 1'b1;
        cyc(1);
        sw_reset_req = 1'b0;
        cyc(1);
        chk(n_rst, 1);
        u_emu.pulse(0);
        src_mask_sel = 1'b0;
        chk(run_state, ST_BREAK);
        fin("src_step");
    endtask
    // access break classes, data qualifier and rmw timing
    task automatic t_access();
        {brk_en, brk_rd_en, brk_wr_en, brk_addr, brk_data} = {3'h7, 32'h100, 32'h5A};
        u_emu.pulse(1);
        for (int c = CLS_FRAME_BUILD_INSTR; c <= CLS_SYSTEM_CALL_INSTR; c++)
            acc(drc_class_t'(c), 1'b0, 32'h100, 32'h0);
        acc(CLS_BIT_SET_INSTR, 1'b1, 32'h100, 32'h5A);
        cyc(2);
        chk(n_bb, 0);
        acc(CLS_BIT_TEST_INSTR, 1'b0, 32'h100, 32'h0);
        cyc(1);
        chk(n_bb, 1);
        brk_data_en = 1'b1;
        u_emu.pulse(1);
        acc(CLS_COMPARE_EXCHANGE_INSTR, 1'b0, 32'h100, 32'h5A);
        acc(CLS_RMW, 1'b1, 32'h100, 32'h5A);
        cyc(2);
        chk(n_bb + n_ba, 1);
        ret(1'b0, 1'b0);
        chk(n_ba, 1);
        fin("access");
    endtask
    // trace loss, point trace filter, deep standby wake
    task automatic t_trace();
        u_emu.pulse(1);
        trc_valid = 1'b1;
        cyc(1);
        trc_valid = 1'b0;
        cyc(1);
        chk(trc_loss, 1'b1);
        trc_loss_clr = 1'b1;
        cyc(1);
        {trc_valid, trc_ready, trc_loss_clr} = 3'h6;
        cyc(1);
        chk(trc_loss, 1'b0);
        {trc_valid, trc_ready, trc_loss_clr} = 3'h5;
        cyc(1);
        {trc_valid, trc_ready, trc_loss_clr} = 3'h0;
        chk(trc_loss, 1'b1);
        {trc_en, trc_point_mode, trc_data_en, trc_rd_en, trc_addr, trc_data} = {4'hF, 32'h200, 32'hAA};
        acc(CLS_PLAIN, 1'b0, 32'h200, 32'h55);
        acc(CLS_PLAIN, 1'b1, 32'h200, 32'hAA);
        cyc(2);
        chk(n_tr, 1);
        trc_wr_en = 1'b1;
        acc(CLS_PLAIN, 1'b1, 32'h200, 32'h11);
        cyc(1);
        chk(n_tr, 2);
        ret(1'b0, 1'b1);
        chk({deep_standby_mode, iso_power_off}, 2'h2);
        dbg_mem_access = 1'b1;
        cyc(1);
        dbg_mem_access = 1'b0;
        cyc(1);
        chk(deep_standby_mode, 1'b0);
        // pod unplugged: the isolated domain may now power down
        u_emu.conn = 1'b0;
        ret(1'b0, 1'b1);
        chk({deep_standby_mode, iso_power_off}, 2'h3);
        dbg_event_set = 1'b1;
        cyc(1);
        dbg_event_set = 1'b0;
        chk({deep_standby_mode, dstby_wake}, 2'h1);
        u_emu.conn = 1'b1;
        fin("trace_standby");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {reset_n, src_mask_sel, dbg_mem_access, dbg_event_set, acc_valid, acc_write, instr_retire, retire_halt,
         retire_dstby, sw_reset_req, brk_en, brk_data_en, brk_rd_en, brk_wr_en, trc_en, trc_point_mode,
         trc_data_en, trc_rd_en, trc_wr_en, trc_valid, trc_ready, trc_loss_clr, acc_addr, brk_addr, trc_addr,
         acc_data, brk_data, trc_data, irq_req, irq_ack} = '0;
        target_reset_n = 1'b1;
        acc_class = CLS_PLAIN;
        cyc(16);
        reset_n = 1'b1;
        cyc(2);
        t_halt();
        t_resets();
        t_step();
        t_src();
        t_access();
        t_trace();
        test_done();
    end
endmodule
